/* File: logic/pma_pmd_mgmt_regs.sv */
// pma/pmd management register bank reached by clause 45 register accesses
//
// Overview of operation
// - registers at device 1, documented addresses
// - status two bits 15:14 read 2
// - status two bit 9 reads one
// - status two bit 8 reads one
// - status two bit 0 reads one
// - tx disable bit 0 suppresses transmit
// - extended ability bit 11 reads one
// - single pair ability is read only
// - ability reports long reach only
// - control bit 14 selects leader role
// - role bit used only without negotiation
// - type field resets 2, four codes
// - type applied only when forced, no negotiation
// - long reach control bit 14 disables transmit
`timescale 1ns/1ns
`default_nettype none
`include "pma_regs_map.svh"
module pma_pmd_mgmt_regs
(
  input  wire logic                     clk_i,
  input  wire logic                     reset_i,
  input  wire logic                     req_i,
  input  wire logic                     write_i,
  input  wire logic [4:0]               dev_addr_i,
  input  wire logic [15:0]              reg_addr_i,
  input  wire logic [15:0]              wdata_i,
  input  wire logic                     an_enable_i,
  input  wire logic                     forced_cfg_i,
  input  wire logic                     leader_an_i,
  input  wire logic [3:0]               type_an_i,
  output pma_regs_pkg::reg_word_t       rdata_o,
  output logic                          rvalid_o,
  output logic                          hit_o,
  output logic                          tx_enable_o,
  output logic                          leader_o,
  output pma_regs_pkg::phy_type_t       phy_type_o
);
  import pma_regs_pkg::*;
  // ==========================================
  // storage
  logic        tx_output_off_ff;        // tx disable bit
  logic        leader_role_select_ff;   // leader/follower select
  logic [3:0]  phy_type_select_ff;      // forced phy type
  logic        long_reach_tx_off_ff;    // long reach tx disable
  logic        tx_enable_ff;            // transmit enable output
  // ==========================================
  // decode
  wire logic   dev_hit;                 // device 1 addressed
  wire logic   sel_stat2;
  wire logic   sel_txdis;
  wire logic   sel_ext;
  wire logic   sel_spab;
  wire logic   sel_spctl;
  wire logic   sel_lrctl;
  wire logic   any_hit;                 // mapped register
  wire logic   wr;                      // write strobe
  wire reg_word_t read_word;            // read mux output
  assign dev_hit   = (dev_addr_i == `PMA_DEV_ADDR);
  assign sel_stat2 = dev_hit & (reg_addr_i == `STATUS_TWO_ADDR);
  assign sel_txdis = dev_hit & (reg_addr_i == `TX_DISABLE_ADDR);
  assign sel_ext   = dev_hit & (reg_addr_i == `EXT_ABILITY_ADDR);
  assign sel_spab  = dev_hit & (reg_addr_i == `SP_ABILITY_ADDR);
  assign sel_spctl = dev_hit & (reg_addr_i == `SP_CONTROL_ADDR);
  assign sel_lrctl = dev_hit & (reg_addr_i == `LR_CONTROL_ADDR);
  assign any_hit   = sel_stat2 | sel_txdis | sel_ext | sel_spab | sel_spctl | sel_lrctl;
  assign wr        = req_i & write_i;
  // ==========================================
  // read mux, constants for fixed ability words
  assign read_word =
    sel_stat2 ? `STATUS_TWO_VAL :
    sel_txdis ? {15'h0000, tx_output_off_ff} :
    sel_ext   ? `EXT_ABILITY_VAL :
    sel_spab  ? `SP_ABILITY_VAL :
    sel_spctl ? {1'b1, leader_role_select_ff, 10'h000, phy_type_select_ff} :
    sel_lrctl ? {1'b0, long_reach_tx_off_ff, 14'h0000} :
    16'h0000;                                                           // unmapped reads zero
  // ==========================================
  // writable bits; others ignore writes
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      tx_output_off_ff      <= 1'b0;
      leader_role_select_ff <= 1'b0;
      phy_type_select_ff    <= `TYPE_RST;
      long_reach_tx_off_ff  <= 1'b0;
    end
    else if (wr)
    begin
      if (sel_txdis)
      begin
        tx_output_off_ff <= wdata_i[`TX_OFF_BIT];
      end
      if (sel_spctl)
      begin
        leader_role_select_ff <= wdata_i[`LEADER_BIT];
        phy_type_select_ff    <= wdata_i[`TYPE_MSB:`TYPE_LSB];
      end
      if (sel_lrctl)
      begin
        long_reach_tx_off_ff <= wdata_i[`LR_TX_OFF_BIT];
      end
    end
  end
  // ==========================================
  // read answer, one cycle after request
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      rdata_o  <= 16'h0000;
      rvalid_o <= 1'b0;
      hit_o    <= 1'b0;
    end
    else
    begin
      rdata_o  <= (req_i & ~write_i) ? read_word : 16'h0000;
      rvalid_o <= req_i & ~write_i;
      hit_o    <= req_i & any_hit;
    end
  end
  // ==========================================
  // transmit gate: either disable bit suppresses output
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      tx_enable_ff <= 1'b1;
    end
    else
    begin
      tx_enable_ff <= ~(tx_output_off_ff | long_reach_tx_off_ff);
    end
  end
  assign tx_enable_o = tx_enable_ff;
  // ==========================================
  // role and type resolution
  mode_resolve u_mode_resolve
  (
    .clk_i           (clk_i),
    .reset_i         (reset_i),
    .an_enable_i     (an_enable_i),
    .forced_cfg_i    (forced_cfg_i),
    .leader_forced_i (leader_role_select_ff),
    .type_forced_i   (phy_type_select_ff),
    .leader_an_i     (leader_an_i),
    .type_an_i       (type_an_i),
    .leader_o        (leader_o),
    .type_o          (phy_type_o)
  );
endmodule : pma_pmd_mgmt_regs
`default_nettype wire

/* File: logic/pma_regs_map.svh */
// register offsets, field positions and reset values of the pma/pmd register bank
`ifndef PMA_REGS_MAP_SVH
`define PMA_REGS_MAP_SVH
// ==========================================
// device and register addresses
`define PMA_DEV_ADDR        5'h01
`define STATUS_TWO_ADDR     16'h0008
`define TX_DISABLE_ADDR     16'h0009
`define EXT_ABILITY_ADDR    16'h000B
`define SP_ABILITY_ADDR     16'h0012
`define SP_CONTROL_ADDR     16'h0834
`define LR_CONTROL_ADDR     16'h08F6
// ==========================================
// reset and fixed values
`define STATUS_TWO_VAL      16'h8301
`define TX_DISABLE_RST      16'h0000
`define EXT_ABILITY_VAL     16'h0800
`define SP_ABILITY_VAL      16'h0004
`define SP_CONTROL_RST      16'h8002
`define LR_CONTROL_RST      16'h0000
// ==========================================
// field positions
`define TX_OFF_BIT          0
`define LEADER_BIT          14
`define LR_TX_OFF_BIT       14
`define TYPE_LSB            0
`define TYPE_MSB            3
`define TYPE_RST            4'h2
`endif

/* File: logic/pma_regs_pkg.sv */
// types shared by the pma/pmd register bank
`default_nettype none
package pma_regs_pkg;
  // phy type select encodings
  typedef enum logic [3:0]
  {
    TYPE_FAST      = 4'h0,
    TYPE_GIGABIT   = 4'h1,
    TYPE_LONG      = 4'h2,
    TYPE_SHORT     = 4'h3
  } phy_type_t;
  typedef logic [15:0] reg_word_t;
endpackage : pma_regs_pkg
`default_nettype wire

/* File: logic/mode_resolve.sv */
// resolves role and phy type from forced settings or negotiation outcome
`timescale 1ns/1ns
`default_nettype none
module mode_resolve
(
  input  wire logic                     clk_i,
  input  wire logic                     reset_i,
  input  wire logic                     an_enable_i,
  input  wire logic                     forced_cfg_i,
  input  wire logic                     leader_forced_i,
  input  wire logic [3:0]               type_forced_i,
  input  wire logic                     leader_an_i,
  input  wire logic [3:0]               type_an_i,
  output logic                          leader_o,
  output pma_regs_pkg::phy_type_t       type_o
);
  import pma_regs_pkg::*;
  wire logic      use_forced_role;     // forced role allowed
  wire logic      use_forced_type;     // forced type allowed
  wire logic      nxt_leader;          // chosen role
  wire logic [3:0] nxt_type;           // chosen type
  // ==========================================
  // selection
  assign use_forced_role = ~an_enable_i;
  assign use_forced_type = ~an_enable_i & forced_cfg_i;
  assign nxt_leader      = use_forced_role ? leader_forced_i : leader_an_i;
  assign nxt_type        = use_forced_type ? type_forced_i : type_an_i;
  // registered outputs
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      leader_o <= 1'b0;
      type_o   <= TYPE_LONG;
    end
    else
    begin
      leader_o <= nxt_leader;
      type_o   <= phy_type_t'(nxt_type);
    end
  end
endmodule : mode_resolve
`default_nettype wire

/* File: verification/pma_regs_sva.sv */
// port assertions for the pma/pmd register bank
`timescale 1ns/1ns
`default_nettype none
module pma_regs_sva
(
  input wire logic                    clk_i,
  input wire logic                    reset_i,
  input wire logic                    req_i,
  input wire logic                    write_i,
  input wire logic                    an_enable_i,
  input wire logic                    forced_cfg_i,
  input wire logic                    leader_an_i,
  input wire logic [4:0]              dev_addr_i,
  input wire logic [15:0]             reg_addr_i,
  input wire logic [15:0]             wdata_i,
  input wire logic [3:0]              type_an_i,
  input wire pma_regs_pkg::reg_word_t rdata_o,
  input wire logic                    rvalid_o,
  input wire logic                    hit_o,
  input wire logic                    tx_enable_o,
  input wire logic                    leader_o,
  input wire pma_regs_pkg::phy_type_t phy_type_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  // reads and writes aimed at device one
  wire logic rd_1 = req_i && !write_i && dev_addr_i == 5'h01;
  wire logic wr_1 = req_i && write_i && dev_addr_i == 5'h01;
  // ==========================================
  // address map and fixed words
  property p_map; req_i && dev_addr_i != 5'h01 |=> !hit_o && rdata_o == 16'h0000; endproperty
  a_map: assert property (p_map) else $error("foreign device answered");
  property p_stat; rd_1 && reg_addr_i == 16'h0008 |=> rvalid_o && rdata_o[15:14] == 2'h2; endproperty
  a_stat: assert property (p_stat) else $error("presence field wrong");
  property p_caps; rd_1 && reg_addr_i == 16'h0008 |=> rdata_o[9:8] == 2'h3 && rdata_o[0]; endproperty
  a_caps: assert property (p_caps) else $error("status capability bits wrong");
  property p_ext; rd_1 && reg_addr_i == 16'h000B |=> rdata_o[11] && hit_o; endproperty
  a_ext: assert property (p_ext) else $error("extended flag wrong");
  property p_abil; rd_1 && reg_addr_i == 16'h0012 |=> rdata_o == 16'h0004; endproperty
  a_abil: assert property (p_abil) else $error("ability word wrong");
  property p_ro; wr_1 && reg_addr_i == 16'h0012 |=> hit_o && !rvalid_o; endproperty
  a_ro: assert property (p_ro) else $error("ability write answered wrongly");
  // ==========================================
  // outputs derived from the registers
  property p_tx; wr_1 && reg_addr_i == 16'h0009 && wdata_i[0] |-> ##2 !tx_enable_o; endproperty
  a_tx: assert property (p_tx) else $error("transmit not suppressed");
  property p_role; an_enable_i |=> leader_o == $past(leader_an_i); endproperty
  a_role: assert property (p_role) else $error("role not from negotiation");
  property p_type; !(!an_enable_i && forced_cfg_i) |=> phy_type_o == $past(type_an_i); endproperty
  a_type: assert property (p_type) else $error("type not from negotiation");
endmodule : pma_regs_sva
bind pma_pmd_mgmt_regs pma_regs_sva chk (.*);
`default_nettype wire

/* File: verification/mgmt_host_model.sv */
// station management host issuing single register accesses
`timescale 1ns/1ns
`default_nettype none
module mgmt_host_model
(
  input  wire logic                    clk_i,
  input  wire pma_regs_pkg::reg_word_t rdata_i,
  input  wire logic                    hit_i,
  output var logic                     req_o,
  output var logic                     write_o,
  output var logic [4:0]               dev_o,
  output var logic [15:0]              addr_o,
  output var logic [15:0]              wdata_o
);
  initial {req_o, write_o, dev_o, addr_o, wdata_o} = '0;
  // one access held for the taking edge, answer read just after it
  task automatic access(input logic wr, input logic [4:0] dev, input logic [15:0] addr, data,
                        output logic [15:0] rd, output logic hit);
    @(posedge clk_i);
    {req_o, write_o, dev_o, addr_o, wdata_o} <= {1'b1, wr, dev, addr, data};
    @(posedge clk_i);
    // released lines show the inverse, not a stale value
    {req_o, write_o, dev_o, addr_o, wdata_o} <= {1'b0, ~wr, ~dev, ~addr, ~data};
    #1;
    rd = rdata_i;
    hit = hit_i;
  endtask : access
endmodule : mgmt_host_model
`default_nettype wire

/* File: verification/pma_pmd_mgmt_regs_test.sv */
// self-checking bench for the pma/pmd register bank
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin error_cnt++; $display("[ERR] %0t %h %h", $time, g, e); end end
module pma_pmd_mgmt_regs_test;
  import pma_regs_pkg::*;
  typedef struct packed { logic wr; logic [15:0] addr, data, exp; } row_t;
  logic      clk_i = 0, reset_i = 1, an_enable_i = 0, forced_cfg_i = 1, leader_an_i = 0;
  logic      req_i, write_i, rvalid_o, hit_o, tx_enable_o, leader_o, hit;
  logic [3:0]  type_an_i = 4'h0;
  logic [4:0]  dev_addr_i;
  logic [15:0] reg_addr_i, wdata_i, rd;
  reg_word_t rdata_o;
  phy_type_t phy_type_o;
  int        error_cnt = 0, total_checks = 0, cycles = 0;
  // reads of every word but long reach control, writes to read-only and to writable words
  row_t rows [14] = '{'{0, 16'h0008, 0, 16'h8301}, '{0, 16'h0009, 0, 0}, '{0, 16'h000B, 0, 16'h0800},
    '{0, 16'h0012, 0, 16'h0004}, '{0, 16'h0834, 0, 16'h8002}, '{0, 16'h0005, 0, 0},
    '{1, 16'h0012, 16'hFFFF, 0}, '{0, 16'h0012, 0, 16'h0004}, '{1, 16'h0008, 16'hFFFF, 0},
    '{0, 16'h0008, 0, 16'h8301}, '{1, 16'h0834, 16'hFFFF, 0}, '{0, 16'h0834, 0, 16'hC00F},
    '{1, 16'h0009, 16'hFFFE, 0}, '{0, 16'h0009, 0, 0}};
  always #5 clk_i = ~clk_i;
  mgmt_host_model host (.clk_i(clk_i), .rdata_i(rdata_o), .hit_i(hit_o), .req_o(req_i), .write_o(write_i),
    .dev_o(dev_addr_i), .addr_o(reg_addr_i), .wdata_o(wdata_i));
  pma_pmd_mgmt_regs uut (.clk_i(clk_i), .reset_i(reset_i), .req_i(req_i), .write_i(write_i),
    .dev_addr_i(dev_addr_i), .reg_addr_i(reg_addr_i), .wdata_i(wdata_i), .an_enable_i(an_enable_i),
    .forced_cfg_i(forced_cfg_i), .leader_an_i(leader_an_i), .type_an_i(type_an_i), .rdata_o(rdata_o),
    .rvalid_o(rvalid_o), .hit_o(hit_o), .tx_enable_o(tx_enable_o), .leader_o(leader_o), .phy_type_o(phy_type_o));
  // write to device one, then let the derived outputs follow
  task automatic put(input logic [15:0] a, d);
    host.access(1'b1, 5'h01, a, d, rd, hit);
    @(posedge clk_i);
    #1;
  endtask : put
  task automatic print_verdict;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : print_verdict
  // hang guard
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      error_cnt++;
      print_verdict();
    end
  end
  initial
  begin
    repeat (6) @(posedge clk_i);
    reset_i <= 0;
    #1;
    `CHK({tx_enable_o, leader_o, phy_type_o}, {1'b1, 1'b0, TYPE_LONG})
    foreach (rows[i])
    begin
      host.access(rows[i].wr, 5'h01, rows[i].addr, rows[i].data, rd, hit);
      `CHK(hit, rows[i].addr != 16'h0005)
      if (!rows[i].wr) `CHK(rd, rows[i].exp)
    end
    `CHK(leader_o, 1'b1)
    for (int c = 0; c < 4; c++)
    begin
      put(16'h0834, 16'(c));
      `CHK({leader_o, phy_type_o}, {1'b0, 4'(c)})
    end
    put(16'h0834, 16'h4002); // long reach code restored
    @(posedge clk_i) {an_enable_i, leader_an_i, type_an_i} <= {2'b10, 4'h3};
    @(posedge clk_i) #1;
    `CHK({leader_o, phy_type_o}, {1'b0, TYPE_SHORT})
    @(posedge clk_i) {an_enable_i, forced_cfg_i} <= 2'b00;
    @(posedge clk_i) #1;
    `CHK({leader_o, phy_type_o}, {1'b1, TYPE_SHORT})
    put(16'h0009, 16'h0001);
    `CHK(tx_enable_o, 1'b0)
    put(16'h0009, 16'h0000);
    `CHK(tx_enable_o, 1'b1)
    put(16'h08F6, 16'h4000);
    `CHK(tx_enable_o, 1'b0)
    host.access(1'b0, 5'h02, 16'h0008, 0, rd, hit);
    `CHK({hit, rd}, 17'h0)
    @(posedge clk_i) reset_i <= 1;
    repeat (2) @(posedge clk_i);
    reset_i <= 0;
    #1;
    `CHK({tx_enable_o, leader_o}, 2'b10)
    print_verdict();
  end
endmodule : pma_pmd_mgmt_regs_test
`default_nettype wire
